// *** flash_seq_pkg.sv ***
// Shared constants and types of the erase and program sequencer.
package flash_seq_pkg;

	// ----------------------------------------------------------------
	// Opcodes, timing base and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_ERASE_LARGE_BLOCK = 8'hd8;
	localparam logic [7:0] OP_PROGRAM_TWO_LANE  = 8'ha2;
	localparam logic [7:0] OP_PROGRAM_FOUR_LANE = 8'h32;
	localparam logic [7:0] OP_ERASE_SECURE      = 8'h44;
	localparam int         CLK_MHZ              = 25;
	localparam int         SMALL_BLOCK_LSB      = 15;
	localparam int         LARGE_BLOCK_LSB      = 16;
	localparam int         SECURE_SEL_LSB       = 12;
	localparam logic [3:0] SECURE_SEL_FIRST     = 4'h1;
	localparam logic [3:0] SECURE_SEL_LAST      = 4'h3;
	localparam logic [2:0] BYTES_ADDR_CMD       = 3'h4;
	localparam logic [2:0] BYTES_NO_ADDR_CMD    = 3'h1;
	localparam logic [2:0] BYTES_WITH_DATA      = 3'h5;
	localparam logic [7:0] PAGE_LAST_INDEX      = 8'hff;

	typedef enum logic [2:0] {
		CMD_NONE        = 3'b000,
		CMD_ERASE_SMALL = 3'b001,
		CMD_ERASE_LARGE = 3'b010,
		CMD_ERASE_ARRAY = 3'b011,
		CMD_ERASE_SEC   = 3'b100,
		CMD_PROG_ONE    = 3'b101,
		CMD_PROG_TWO    = 3'b110,
		CMD_PROG_FOUR   = 3'b111
	} cmd_t;

	typedef enum logic [1:0] {
		ERASE_SMALL  = 2'b00,
		ERASE_LARGE  = 2'b01,
		ERASE_ARRAY  = 2'b10,
		ERASE_SECURE = 2'b11
	} erase_kind_t;

endpackage

// *** pin_sampler.sv ***
// Two-flop synchronisers and edge detection for the serial pins.
`timescale 1ns/10ps
module pin_sampler (
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_cs_n,
	input  wire logic       i_sclk,
	input  wire logic [3:0] i_lanes,
	output logic            o_cs_low,
	output logic            o_cs_rise,
	output logic            o_cs_fall,
	output logic            o_sclk_rise,
	output logic [3:0]      o_lanes
);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// Lanes travel through the same depth as the clock so that data
	// stays aligned with the detected rising edge.
	logic [5:0] meta_ff;
	logic [5:0] sync_ff;
	logic [1:0] last_ff;

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			meta_ff <= 6'h01;
			sync_ff <= 6'h01;
			last_ff <= 2'h1;
		end else begin
			meta_ff <= {i_lanes, i_sclk, i_cs_n};
			sync_ff <= meta_ff;
			last_ff <= sync_ff[1:0];
		end
	end

	assign o_cs_low    = !sync_ff[0];
	assign o_cs_rise   = sync_ff[0] && !last_ff[0];
	assign o_cs_fall   = !sync_ff[0] && last_ff[0];
	assign o_sclk_rise = sync_ff[1] && !last_ff[1];
	assign o_lanes     = sync_ff[5:2];

endmodule

// *** flash_sequencer.sv ***
// Erase and page program command sequencer of the serial flash.
// Behaviour
// - Erase or program refused unless latch set.
// - Chip select rising mid-byte discards command.
// - Small erase clears whole containing 32K block.
// - Opcode D8 erases whole containing 64K block.
// - Erase drives ones; program only clears bits.
// - Cycle starts at select rise; latch clears after.
// - Busy flag stays readable during the cycle.
// - Protected small block: array kept, latch cleared.
// - Protected large block or page not executed.
// - Array erase only when protection fully off.
// - Program keeps only last 256 data bytes.
// - Data past page end wraps within page.
// - Unsent page locations stay untouched.
// - Program needs whole data byte, at least one.
// - Single-lane commands sample lane zero only.
// - Opcode A2 takes data two bits per clock.
// - Opcode 32 four-lane data needs quad enable.
// - Three secure regions selected by address fields.
// - Opcode 44 erases chosen secure region, self-timed.
// - Incomplete last byte cancels secure erase.
// - Locked secure region can never be erased.
`timescale 1ns/10ps
module flash_sequencer import flash_seq_pkg::*; #(
	parameter logic [7:0] P_OP_ERASE_SMALL  = 8'h52,
	parameter logic [7:0] P_OP_ERASE_ARRAY  = 8'hc7,
	parameter logic [7:0] P_OP_PROGRAM_ONE  = 8'h02,
	parameter int         P_SMALL_ERASE_US  = 100000,
	parameter int         P_LARGE_ERASE_US  = 200000,
	parameter int         P_ARRAY_ERASE_US  = 400000,
	parameter int         P_PAGE_PROGRAM_US = 1000,
	parameter int         P_SECURE_ERASE_US = 50000
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic        i_io_lane0,
	input  wire logic        i_io_lane1,
	input  wire logic        i_io_lane2,
	input  wire logic        i_io_lane3,
	input  wire logic        i_set_write_latch,
	input  wire logic        i_quad_enable_bit,
	input  wire logic        i_protect_level_bit4,
	input  wire logic        i_protect_level_bit3,
	input  wire logic        i_protect_level_bit2,
	input  wire logic        i_protect_level_bit1,
	input  wire logic        i_protect_level_bit0,
	input  wire logic [2:0]  i_secure_region_lock_bits,
	input  wire logic        i_addr_protected,
	output logic             o_write_enable_latch,
	output logic             o_write_in_progress,
	output logic [23:0]      o_check_addr,
	output logic             o_erase_start,
	output erase_kind_t      o_erase_kind,
	output logic [23:0]      o_erase_base,
	output logic             o_prog_we,
	output logic [23:0]      o_prog_addr,
	output logic [7:0]       o_prog_data
);

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam logic [31:0] SMALL_CYC  = 32'(P_SMALL_ERASE_US * CLK_MHZ);
	localparam logic [31:0] LARGE_CYC  = 32'(P_LARGE_ERASE_US * CLK_MHZ);
	localparam logic [31:0] ARRAY_CYC  = 32'(P_ARRAY_ERASE_US * CLK_MHZ);
	localparam logic [31:0] PROG_CYC   = 32'(P_PAGE_PROGRAM_US * CLK_MHZ);
	localparam logic [31:0] SECURE_CYC = 32'(P_SECURE_ERASE_US * CLK_MHZ);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPC  = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b011,
		ST_SKIP = 3'b100
	} frame_st_t;

	typedef enum logic [1:0] {
		EX_IDLE  = 2'b00,
		EX_WRITE = 2'b01,
		EX_WAIT  = 2'b10
	} exec_st_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] lane_width(input frame_st_t st, input cmd_t cmd);
		lane_width = 4'd1;
		if (st == ST_DATA && cmd == CMD_PROG_TWO)
			lane_width = 4'd2;
		if (st == ST_DATA && cmd == CMD_PROG_FOUR)
			lane_width = 4'd4;
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] ln, input logic [3:0] w);
		unique case (w)
			4'd2:    shift_in = {sh[5:0], ln[1:0]};
			4'd4:    shift_in = {sh[3:0], ln};
			default: shift_in = {sh[6:0], ln[0]};
		endcase
	endfunction

	function automatic logic [31:0] cycle_count(input cmd_t cmd);
		unique case (cmd)
			CMD_ERASE_SMALL: cycle_count = SMALL_CYC;
			CMD_ERASE_LARGE: cycle_count = LARGE_CYC;
			CMD_ERASE_ARRAY: cycle_count = ARRAY_CYC;
			CMD_ERASE_SEC:   cycle_count = SECURE_CYC;
			default:         cycle_count = PROG_CYC;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	logic       cs_low;
	logic       cs_rise;
	logic       cs_fall;
	logic       sclk_rise;
	logic [3:0] lanes;

	pin_sampler u_pins (
		.i_core_clk  (i_core_clk),
		.i_rstn      (i_rstn),
		.i_cs_n      (i_cs_n),
		.i_sclk      (i_sclk),
		.i_lanes     ({i_io_lane3, i_io_lane2, i_io_lane1, i_io_lane0}),
		.o_cs_low    (cs_low),
		.o_cs_rise   (cs_rise),
		.o_cs_fall   (cs_fall),
		.o_sclk_rise (sclk_rise),
		.o_lanes     (lanes)
	);

	// ----------------------------------------------------------------
	// Frame decoder
	// ----------------------------------------------------------------
	frame_st_t   frame_ff;
	cmd_t        cmd_ff;
	cmd_t        nxt_cmd;
	logic [7:0]  shift_ff;
	logic [2:0]  bitcnt_ff;
	logic [2:0]  nbytes_ff;
	logic [23:0] addr_ff;
	logic [7:0]  didx_ff;
	logic        busy_ff;
	logic        latch_ff;
	logic [3:0]  width;
	logic [7:0]  nxt_shift;
	logic [3:0]  bits_sum;
	logic        take_bit;
	logic        byte_done;
	logic        prot_off;
	logic        launch;
	logic        refuse_prot;
	logic        secure_ok;
	logic [7:0]  page_mem [256];
	logic [255:0] valid_ff;

	assign width     = lane_width(frame_ff, cmd_ff);
	assign nxt_shift = shift_in(shift_ff, lanes, width);
	assign bits_sum  = {1'b0, bitcnt_ff} + width;
	assign take_bit  = sclk_rise && cs_low && frame_ff != ST_IDLE && frame_ff != ST_SKIP;
	assign byte_done = take_bit && bits_sum[3];
	assign prot_off  = !(i_protect_level_bit4 || i_protect_level_bit3 || i_protect_level_bit2 ||
	                     i_protect_level_bit1 || i_protect_level_bit0);
	assign o_check_addr = addr_ff;

	always_comb begin
		nxt_cmd = CMD_NONE;
		if (nxt_shift == P_OP_ERASE_SMALL)
			nxt_cmd = CMD_ERASE_SMALL;
		else if (nxt_shift == OP_ERASE_LARGE_BLOCK)
			nxt_cmd = CMD_ERASE_LARGE;
		else if (nxt_shift == P_OP_ERASE_ARRAY)
			nxt_cmd = CMD_ERASE_ARRAY;
		else if (nxt_shift == OP_ERASE_SECURE)
			nxt_cmd = CMD_ERASE_SEC;
		else if (nxt_shift == P_OP_PROGRAM_ONE)
			nxt_cmd = CMD_PROG_ONE;
		else if (nxt_shift == OP_PROGRAM_TWO_LANE)
			nxt_cmd = CMD_PROG_TWO;
		else if (nxt_shift == OP_PROGRAM_FOUR_LANE && i_quad_enable_bit)
			nxt_cmd = CMD_PROG_FOUR;
	end

	// Secure erase address must name one of three regions and nothing else.
	assign secure_ok = addr_ff[23:16] == 8'h00 && addr_ff[11:9] == 3'h0 &&
	                   addr_ff[15:12] >= SECURE_SEL_FIRST && addr_ff[15:12] <= SECURE_SEL_LAST &&
	                   !i_secure_region_lock_bits[2'(addr_ff[15:12] - SECURE_SEL_FIRST)];

	// A command counts only when select rises on a byte boundary with the exact byte count, or five or more bytes for program.
	always_comb begin
		launch      = 1'b0;
		refuse_prot = 1'b0;
		if (cs_rise && bitcnt_ff == 3'h0 && frame_ff != ST_IDLE && frame_ff != ST_SKIP) begin
			unique case (cmd_ff)
				CMD_ERASE_SMALL, CMD_ERASE_LARGE: begin
					if (nbytes_ff == BYTES_ADDR_CMD) begin
						launch      = !i_addr_protected;
						refuse_prot = i_addr_protected;
					end
				end
				CMD_ERASE_ARRAY: launch = nbytes_ff == BYTES_NO_ADDR_CMD && prot_off;
				CMD_ERASE_SEC:   launch = nbytes_ff == BYTES_ADDR_CMD && secure_ok;
				CMD_NONE:        launch = 1'b0;
				default: begin
					if (nbytes_ff == BYTES_WITH_DATA) begin
						launch      = !i_addr_protected;
						refuse_prot = i_addr_protected;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			frame_ff  <= ST_IDLE;
			cmd_ff    <= CMD_NONE;
			shift_ff  <= 8'h00;
			bitcnt_ff <= 3'h0;
			nbytes_ff <= 3'h0;
		end else if (cs_fall) begin
			frame_ff  <= ST_OPC;
			cmd_ff    <= CMD_NONE;
			bitcnt_ff <= 3'h0;
			nbytes_ff <= 3'h0;
		end else if (!cs_low) begin
			frame_ff <= ST_IDLE;
		end else if (take_bit) begin
			shift_ff  <= nxt_shift;
			bitcnt_ff <= bits_sum[2:0];
			if (byte_done) begin
				if (nbytes_ff != BYTES_WITH_DATA)
					nbytes_ff <= nbytes_ff + 3'h1;
				unique case (frame_ff)
					ST_OPC: begin
						cmd_ff <= nxt_cmd;
						if (busy_ff || !latch_ff || nxt_cmd == CMD_NONE)
							frame_ff <= ST_SKIP;
						else
							frame_ff <= ST_ADDR;
					end
					ST_ADDR: begin
						if (nbytes_ff == 3'h3 && cmd_ff >= CMD_PROG_ONE)
							frame_ff <= ST_DATA;
					end
					default: frame_ff <= frame_ff;
				endcase
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn)
			addr_ff <= 24'h000000;
		else if (byte_done && frame_ff == ST_ADDR && nbytes_ff <= 3'h3)
			addr_ff <= {addr_ff[15:0], nxt_shift};
	end

	// ----------------------------------------------------------------
	// Page buffer
	// ----------------------------------------------------------------
	// The index wraps inside the page, so an overrun simply overwrites the
	// oldest bytes and only the last 256 survive.
	always_ff @(posedge i_core_clk) begin
		if (byte_done && frame_ff == ST_DATA)
			page_mem[addr_ff[7:0] + didx_ff] <= nxt_shift;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			valid_ff <= '0;
			didx_ff  <= 8'h00;
		end else if (frame_ff == ST_OPC) begin
			if (!busy_ff)
				valid_ff <= '0;
			didx_ff <= 8'h00;
		end else if (byte_done && frame_ff == ST_DATA) begin
			valid_ff[addr_ff[7:0] + didx_ff] <= 1'b1;
			didx_ff <= didx_ff + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Self-timed cycle
	// ----------------------------------------------------------------
	exec_st_t    exec_ff;
	logic [31:0] timer_ff;
	logic [7:0]  widx_ff;
	logic        done;

	assign done = exec_ff == EX_WAIT && timer_ff == 32'h0;

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			exec_ff  <= EX_IDLE;
			busy_ff  <= 1'b0;
			timer_ff <= 32'h0;
			widx_ff  <= 8'h00;
		end else begin
			unique case (exec_ff)
				EX_IDLE: begin
					if (launch) begin
						busy_ff  <= 1'b1;
						timer_ff <= cycle_count(cmd_ff);
						widx_ff  <= 8'h00;
						exec_ff  <= cmd_ff >= CMD_PROG_ONE ? EX_WRITE : EX_WAIT;
					end
				end
				EX_WRITE: begin
					widx_ff <= widx_ff + 8'h01;
					if (widx_ff == PAGE_LAST_INDEX)
						exec_ff <= EX_WAIT;
				end
				EX_WAIT: begin
					if (done) begin
						busy_ff <= 1'b0;
						exec_ff <= EX_IDLE;
					end else begin
						timer_ff <= timer_ff - 32'h1;
					end
				end
				default: exec_ff <= EX_IDLE;
			endcase
		end
	end

	// Set from outside is honoured only while idle, so it cannot race the end-of-cycle clear; a same-cycle protection refusal clear wins over it.
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn)
			latch_ff <= 1'b0;
		else if (done || refuse_prot)
			latch_ff <= 1'b0;
		else if (i_set_write_latch && !busy_ff)
			latch_ff <= 1'b1;
	end

	assign o_write_enable_latch = latch_ff;
	assign o_write_in_progress  = busy_ff;

	// ----------------------------------------------------------------
	// Array requests
	// ----------------------------------------------------------------
	// Program data is an AND mask: ones leave a bit alone, so bits only fall.
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_erase_start <= 1'b0;
			o_erase_kind  <= ERASE_SMALL;
			o_erase_base  <= 24'h000000;
			o_prog_we     <= 1'b0;
			o_prog_addr   <= 24'h000000;
			o_prog_data   <= 8'hff;
		end else begin
			o_erase_start <= launch && cmd_ff < CMD_PROG_ONE;
			if (launch) begin
				unique case (cmd_ff)
					CMD_ERASE_SMALL: begin
						o_erase_kind <= ERASE_SMALL;
						o_erase_base <= {addr_ff[23:SMALL_BLOCK_LSB], 15'h0000};
					end
					CMD_ERASE_LARGE: begin
						o_erase_kind <= ERASE_LARGE;
						o_erase_base <= {addr_ff[23:LARGE_BLOCK_LSB], 16'h0000};
					end
					CMD_ERASE_ARRAY: begin
						o_erase_kind <= ERASE_ARRAY;
						o_erase_base <= 24'h000000;
					end
					default: begin
						o_erase_kind <= ERASE_SECURE;
						o_erase_base <= {addr_ff[23:SECURE_SEL_LSB], 12'h000};
					end
				endcase
			end
			o_prog_we   <= exec_ff == EX_WRITE && valid_ff[widx_ff];
			o_prog_addr <= {addr_ff[23:8], widx_ff};
			o_prog_data <= exec_ff == EX_WRITE ? page_mem[widx_ff] : 8'hff;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_start_needs_latch: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		$rose(busy_ff) |-> $past(latch_ff)) else $error("Cycle began without write latch.");
	a_partial_byte_drop: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(cs_rise && bitcnt_ff != 3'h0 && !busy_ff) |=> !busy_ff) else $error("Partial byte launched cycle.");
	a_small_block_base: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(o_erase_start && o_erase_kind == ERASE_SMALL) |-> o_erase_base[14:0] == 15'h0000)
		else $error("Small erase base unaligned.");
	a_large_block_base: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(o_erase_start && o_erase_kind == ERASE_LARGE) |-> o_erase_base[15:0] == 16'h0000)
		else $error("Large erase base unaligned.");
	a_wip_end_latch: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		$fell(o_write_in_progress) |-> !o_write_enable_latch) else $error("Latch held after cycle.");
	a_array_guard: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(o_erase_start && o_erase_kind == ERASE_ARRAY) |-> $past(prot_off)) else $error("Array erase while protected.");
	a_busy_ignore: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(frame_ff == ST_OPC && byte_done && busy_ff && !cs_fall) |=> frame_ff == ST_SKIP)
		else $error("Command accepted while busy.");
	a_secure_select: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(o_erase_start && o_erase_kind == ERASE_SECURE) |->
		o_erase_base[23:16] == 8'h00 && o_erase_base[15:12] inside {4'h1, 4'h2, 4'h3})
		else $error("Secure erase outside regions.");
	a_page_wrap: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_prog_we |-> o_prog_addr[23:8] == addr_ff[23:8]) else $error("Program left its page.");

endmodule

// *** flash_host_model.sv ***
// Host-side serial controller model that drives the sequencer's link pins.
`timescale 1ns/10ps
module flash_host_model (
	input  wire logic       i_core_clk,
	output logic            o_cs_n,
	output logic            o_sclk,
	output logic [3:0]      o_lanes
);
	initial begin
		o_cs_n  = 1'b1;
		o_sclk  = 1'b0;
		o_lanes = 4'h0;
	end

	// ----------------------------------------------------------------
	// Data pattern and frame driver
	// ----------------------------------------------------------------
	function automatic logic [7:0] pat(input int i);
		return 8'(i * 37 + i / 256 * 101 + 5);
	endfunction

	// Lanes change while the serial clock is low, so they are settled at its rising edge.
	task automatic tick(input logic [3:0] v);
		@(posedge i_core_clk);
		o_lanes <= v;
		o_sclk  <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		o_sclk <= 1'b1;
		repeat (3) @(posedge i_core_clk);
	endtask

	task automatic send(input logic [7:0] op, input logic [23:0] addr, input int hdr, nd, w, extra);
		logic [31:0] h;
		logic [7:0]  sh;
		h = {op, addr};
		@(posedge i_core_clk);
		o_cs_n <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		for (int i = 0; i < hdr * 8; i++) begin
			tick({~h[31], h[31], ~h[31], h[31]});
			h = h << 1;
		end
		for (int j = 0; j < nd; j++) begin
			sh = pat(j);
			for (int k = 0; k < 8; k += w) begin
				tick(w == 4 ? sh[7:4] : w == 2 ? {~sh[7], sh[6], sh[7:6]} : {~sh[7], sh[7], ~sh[7], sh[7]});
				sh = sh << w;
			end
		end
		for (int e = 0; e < extra; e++) tick(4'h5);
		@(posedge i_core_clk);
		o_sclk <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		o_cs_n  <= 1'b1;
		o_lanes <= ~o_lanes;
		repeat (8) @(posedge i_core_clk);
	endtask
endmodule

// *** test_flash_sequencer.sv ***
// Self-checking testbench of the erase and program sequencer.
`timescale 1ns/10ps
module test_flash_sequencer import flash_seq_pkg::*;;
	localparam logic [7:0] OP_SMALL = 8'h52;
	localparam logic [7:0] OP_ARRAY = 8'hc7;
	localparam logic [7:0] OP_PROG  = 8'h02;
	localparam int         SMALL_N  = 25;
	localparam int         LARGE_N  = 500;
	logic        i_core_clk, i_rstn, cs_n, sclk, set_latch, quad_en, prot_hit, addr_prot;
	logic [3:0]  lanes;
	logic [4:0]  prot;
	logic [2:0]  locks;
	logic        write_enable_latch, write_in_progress, e_start, p_we;
	erase_kind_t e_kind, kind_seen;
	logic [23:0] chk_addr, e_base, p_addr, base_seen;
	logic [7:0]  p_data;
	logic [7:0]  pg_data [256];
	logic [15:0] pg_page;
	int          failures = 0, n_tests = 0, cycles = 0, n_starts = 0, run = 0, last_run = 0, pg_n = 0;

	// Protection decode stands outside the block; block 07 is the protected one.
	assign addr_prot = prot_hit && chk_addr[23:16] == 8'h07;

	flash_host_model host (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_lanes(lanes));

	flash_sequencer #(.P_SMALL_ERASE_US(1), .P_LARGE_ERASE_US(20), .P_ARRAY_ERASE_US(1), .P_PAGE_PROGRAM_US(1),
		.P_SECURE_ERASE_US(1)) dut (
		.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_io_lane0(lanes[0]), .i_io_lane1(lanes[1]), .i_io_lane2(lanes[2]), .i_io_lane3(lanes[3]),
		.i_set_write_latch(set_latch), .i_quad_enable_bit(quad_en),
		.i_protect_level_bit4(prot[4]), .i_protect_level_bit3(prot[3]), .i_protect_level_bit2(prot[2]),
		.i_protect_level_bit1(prot[1]), .i_protect_level_bit0(prot[0]),
		.i_secure_region_lock_bits(locks), .i_addr_protected(addr_prot),
		.o_write_enable_latch(write_enable_latch), .o_write_in_progress(write_in_progress), .o_check_addr(chk_addr),
		.o_erase_start(e_start), .o_erase_kind(e_kind), .o_erase_base(e_base),
		.o_prog_we(p_we), .o_prog_addr(p_addr), .o_prog_data(p_data));

	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	// ----------------------------------------------------------------
	// Monitors, timeout and reporting
	// ----------------------------------------------------------------
	always @(negedge i_core_clk) begin
		if (e_start === 1'b1) begin
			n_starts++;
			kind_seen = e_kind;
			base_seen = e_base;
		end
		if (p_we === 1'b1) begin
			pg_n++;
			pg_data[p_addr[7:0]] = p_data;
			pg_page = p_addr[23:8];
		end
		if (write_in_progress === 1'b1) run++;
		else if (run != 0) begin
			last_run = run;
			run = 0;
		end
	end

	// The ceiling is about three times the expected run length.
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim;
		if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic set_wel;
		@(posedge i_core_clk);
		set_latch <= 1'b1;
		@(posedge i_core_clk);
		set_latch <= 1'b0;
		repeat (2) @(negedge i_core_clk);
	endtask

	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int hdr, nd, w, ex);
		host.send(op, a, hdr, nd, w, ex);
		repeat (4) @(negedge i_core_clk);
		for (int i = 0; i < 20000 && write_in_progress !== 1'b0; i++) @(negedge i_core_clk);
		@(negedge i_core_clk);
	endtask

	task automatic erase_ok(input logic [7:0] op, input logic [23:0] a, input int hdr, input erase_kind_t k,
			input logic [23:0] b, input int n);
		int s;
		s = n_starts;
		set_wel();
		check(write_enable_latch, 1'b1);
		cmd(op, a, hdr, 0, 1, 0);
		check(n_starts - s, 1);
		check(kind_seen, k);
		check(base_seen, b);
		check(write_enable_latch, 1'b0);
		check(last_run >= n && last_run <= n + 1, 1);
	endtask

	task automatic refused(input logic [7:0] op, input logic [23:0] a, input int hdr, nd, w, ex,
			input bit latch, input logic exp_wel);
		int s;
		s = n_starts + pg_n;
		if (latch) set_wel();
		cmd(op, a, hdr, nd, w, ex);
		check(n_starts + pg_n - s, 0);
		check(write_enable_latch, exp_wel);
		check(write_in_progress, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_erase;
		int s;
		refused(OP_ERASE_LARGE_BLOCK, 24'h123456, 4, 0, 1, 0, 0, 1'b0);
		erase_ok(OP_SMALL, 24'h129abc, 4, ERASE_SMALL, 24'h128000, SMALL_N);
		erase_ok(OP_ERASE_LARGE_BLOCK, 24'h12ffff, 4, ERASE_LARGE, 24'h120000, LARGE_N);
		s = n_starts;
		set_wel();
		host.send(OP_ERASE_LARGE_BLOCK, 24'h340000, 4, 0, 1, 0);
		cmd(OP_SMALL, 24'h560000, 4, 0, 1, 0);
		check(n_starts - s, 1);
		check(base_seen, 24'h340000);
		refused(OP_ERASE_LARGE_BLOCK, 24'h120000, 4, 0, 1, 3, 1, 1'b1);
		refused(OP_ERASE_SECURE, 24'h001000, 4, 0, 1, 5, 0, 1'b1);
	endtask

	task automatic t_protect;
		@(posedge i_core_clk);
		prot_hit <= 1'b1;
		refused(OP_SMALL, 24'h070000, 4, 0, 1, 0, 1, 1'b0);
		refused(OP_ERASE_LARGE_BLOCK, 24'h07abcd, 4, 0, 1, 0, 1, 1'b0);
		refused(OP_PROG, 24'h070100, 4, 1, 1, 0, 1, 1'b0);
		@(posedge i_core_clk);
		prot_hit <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			@(posedge i_core_clk);
			prot <= 5'(1 << i);
			refused(OP_ARRAY, 24'h0, 1, 0, 1, 0, 1, 1'b1);
		end
		@(posedge i_core_clk);
		prot <= 5'h00;
		erase_ok(OP_ARRAY, 24'h0, 1, ERASE_ARRAY, 24'h0, SMALL_N);
	endtask

	task automatic t_secure;
		logic [23:0] bad [4];
		bad = '{24'h004000, 24'h000000, 24'h001200, 24'h011000};
		@(posedge i_core_clk);
		locks <= 3'b010;
		erase_ok(OP_ERASE_SECURE, 24'h0011ab, 4, ERASE_SECURE, 24'h001000, SMALL_N);
		erase_ok(OP_ERASE_SECURE, 24'h0030ff, 4, ERASE_SECURE, 24'h003000, SMALL_N);
		refused(OP_ERASE_SECURE, 24'h002000, 4, 0, 1, 0, 1, 1'b1);
		for (int i = 0; i < 4; i++) refused(OP_ERASE_SECURE, bad[i], 4, 0, 1, 0, 0, 1'b1);
	endtask

	task automatic t_program;
		pg_n = 0;
		set_wel();
		cmd(OP_PROG, 24'h0402fe, 4, 3, 1, 0);
		check(pg_n, 3);
		check(pg_page, 16'h0402);
		check(pg_data[8'hfe], host.pat(0));
		check(pg_data[8'h00], host.pat(2));
		check(write_enable_latch, 1'b0);
		pg_n = 0;
		set_wel();
		cmd(OP_PROGRAM_TWO_LANE, 24'h000010, 4, 2, 2, 0);
		check(pg_n, 2);
		check(pg_data[8'h11], host.pat(1));
		refused(OP_PROGRAM_FOUR_LANE, 24'h0, 4, 1, 4, 0, 1, 1'b1);
		@(posedge i_core_clk);
		quad_en <= 1'b1;
		pg_n = 0;
		set_wel();
		cmd(OP_PROGRAM_FOUR_LANE, 24'h000100, 4, 257, 4, 0);
		check(pg_n, 256);
		check(pg_data[8'h00], host.pat(256));
		check(pg_data[8'hff], host.pat(255));
		check(p_data, 8'hff);
		refused(OP_PROG, 24'h000200, 4, 0, 1, 0, 1, 1'b1);
		refused(OP_PROG, 24'h000200, 4, 1, 1, 4, 0, 1'b1);
	endtask

	initial begin
		i_rstn    = 1'b0;
		set_latch = 1'b0;
		quad_en   = 1'b0;
		prot_hit  = 1'b0;
		prot      = 5'h00;
		locks     = 3'h0;
		repeat (2) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		t_erase();
		t_protect();
		t_secure();
		t_program();
		end_sim();
	end
endmodule
